//--- dv/mfl_chk.sv
// Port checker for the multiboot fallback loader
`timescale 1ns/1ns
`include "mfl_regs.vh"
module mfl_chk (
  input wire clk_sys,
  input wire srst,
  input wire sck,
  input wire mosi,
  input wire ss_n,
  input wire init_b,
  input wire done,
  input wire cfg_clear,
  input wire cfg_valid,
  input wire fallback_active,
  input wire reprogram_attempt_flag,
  input wire checksum_fail_flag,
  input wire fallback_loaded_flag
);
  reg [7:0] clr_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////////
  // Long clear phase is measured by a counter, not unrolled
  always @(posedge clk_sys) begin
    if (srst || !cfg_clear) begin
      clr_cnt <= 8'h00;
    end else begin
      clr_cnt <= clr_cnt + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  done_after_load_a: assert property ($rose(done) |-> ss_n && !cfg_clear)
    else $error("done rose while flash still selected");
  clear_drops_a: assert property (cfg_clear |-> !done && !init_b)
    else $error("init or done high during clear");
  clear_len_a: assert property ($fell(cfg_clear) |-> clr_cnt == `MFL_CLEAR_CYCLES)
    else $error("clear phase length wrong");
  sck_high_min_a: assert property ($rose(sck) |-> sck [*3])
    else $error("serial clock high too short");
  sck_idle_a: assert property (ss_n |-> !sck)
    else $error("serial clock toggles with flash deselected");
  mosi_steady_a: assert property (!ss_n && $rose(sck) |-> $stable(mosi))
    else $error("mosi changed at serial clock rise");
  fb_flags_a: assert property (fallback_active |-> reprogram_attempt_flag && checksum_fail_flag)
    else $error("fallback without history flags");
  loaded_flag_a: assert property ($rose(fallback_loaded_flag) |-> checksum_fail_flag ##[0:3] done)
    else $error("fallback loaded flag without done");
  valid_pulse_a: assert property (cfg_valid |-> !ss_n ##1 !cfg_valid)
    else $error("data strobe outside a read");
  fail_stops_a: assert property ($rose(checksum_fail_flag) |-> !done ##[0:8] ss_n)
    else $error("image not abandoned on mismatch");
  cover property ($rose(fallback_loaded_flag));
  cover property ($rose(done) && !checksum_fail_flag);
  cover property ($fell(cfg_clear));
endmodule
bind mfl_loader mfl_chk mfl_chk_i (.clk_sys(clk_sys), .srst(srst), .sck(sck), .mosi(mosi),
  .ss_n(ss_n), .init_b(init_b), .done(done), .cfg_clear(cfg_clear), .cfg_valid(cfg_valid),
  .fallback_active(fallback_active), .reprogram_attempt_flag(reprogram_attempt_flag),
  .checksum_fail_flag(checksum_fail_flag), .fallback_loaded_flag(fallback_loaded_flag));

//--- dv/mfl_flash.sv
// Behavioural serial flash: read opcode, 3-byte address, mode 0
`timescale 1ns/1ns
module mfl_flash (
  input  wire sck,
  input  wire ss_n,
  input  wire mosi,
  output reg  miso
);
  reg [31:0] mem [0:127];
  reg [31:0] cmd;
  integer    cnt;
  integer    n;
  initial miso = 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  // Released line flips so a stale bit is never read as data
  always @(posedge ss_n) miso <= ~miso;
  always @(negedge ss_n) cnt = 0;
  always @(posedge sck) begin
    if (!ss_n) begin
      if (cnt < 32) cmd = {cmd[30:0], mosi};
      cnt = cnt + 1;
    end
  end
  // Next bit appears after the falling edge, as a real part answers
  always @(negedge sck) begin
    if (!ss_n && cnt >= 32 && cmd[31:24] == 8'h03) begin
      n = cnt - 32;
      miso <= mem[cmd[23:2] + n / 32][31 - n % 32];
    end
  end
endmodule

//--- dv/mfl_loader_tb.sv
// Self-checking bench for the multiboot fallback loader
`timescale 1ns/1ns
`include "mfl_regs.vh"
module mfl_loader_tb;
  localparam [31:0] ADDR_B = 32'h00000100;
  localparam [31:0] G_DATA = 32'h0000c3c3;
  localparam [31:0] U_DATA = 32'h5a5a0f0f;
  localparam [31:0] G_SUM  = `MFL_CMD_NEXT_ADDR + ADDR_B + G_DATA + `MFL_CMD_CSUM_CHECK;
  localparam [31:0] U_SUM  = U_DATA + `MFL_CMD_CSUM_CHECK;
  localparam [319:0] GOLD  = {32'hffffffff, `MFL_SYNC_WORD, `MFL_CMD_CSUM_RESET,
    `MFL_CMD_NEXT_ADDR, ADDR_B, G_DATA, `MFL_CMD_CSUM_CHECK, G_SUM, `MFL_CMD_REPROGRAM,
    `MFL_CMD_STARTUP_END};
  reg         clk_sys = 1'b0;
  reg         srst = 1'b1;
  reg         restart_n = 1'b1;
  reg  [2:0]  mode_pins = `MFL_MODE_SPI;
  reg         fb_en = 1'b1;
  reg  [7:0]  rate = 8'h04;
  wire        miso, sck, mosi, ss_n, init_b, done, f_rep, f_csum, f_load;
  wire        cfg_valid, cfg_clear, fb_act;
  wire [31:0] cfg_data, next_addr;
  wire [31:0] flags = {28'h0, done, f_rep, f_csum, f_load};
  integer     fails = 0;
  integer     samples_checked = 0;
  integer     cycles = 0;
  integer     nvalid = 0;
  integer     nclr = 0;
  reg  [31:0] last_data = 32'h0;
  mfl_loader mfl_loader_i (.clk_sys(clk_sys), .srst(srst), .restart_n(restart_n),
    .mode_pins(mode_pins), .fallback_enable_option(fb_en), .config_clock_rate(rate),
    .miso(miso), .sck(sck), .mosi(mosi), .ss_n(ss_n), .init_b(init_b), .done(done),
    .cfg_clear(cfg_clear), .cfg_valid(cfg_valid), .cfg_data(cfg_data), .fallback_active(fb_act),
    .reprogram_attempt_flag(f_rep), .checksum_fail_flag(f_csum),
    .fallback_loaded_flag(f_load), .next_image_start_address(next_addr));
  mfl_flash mfl_flash_i (.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso));
  always #5 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 60000) begin
      fails = fails + 1;
      test_done;
    end
    if (cfg_valid === 1'b1) begin
      nvalid = nvalid + 1;
      last_data = cfg_data;
    end
    if (cfg_clear === 1'b1)
      nclr = nclr + 1;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Loads both images, pulses restart and waits for done or a hard error
  task boot(input [31:0] d0, input [31:0] ud, input integer lim);
    reg [223:0] upd;
    integer     i;
    begin
      upd = {`MFL_SYNC_WORD, d0, `MFL_CMD_CSUM_RESET, ud, `MFL_CMD_CSUM_CHECK, U_SUM,
        `MFL_CMD_STARTUP_END};
      for (i = 0; i < 128; i = i + 1) mfl_flash_i.mem[i] = 32'hffffffff;
      for (i = 0; i < 10; i = i + 1) mfl_flash_i.mem[i] = GOLD[319 - 32 * i -: 32];
      for (i = 0; i < 7; i = i + 1) mfl_flash_i.mem[64 + i] = upd[223 - 32 * i -: 32];
      nvalid = 0;
      nclr = 0;
      @(posedge clk_sys) restart_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      restart_n <= 1'b1;
      for (i = 0; i < 20 && cfg_clear !== 1'b1; i = i + 1) @(posedge clk_sys);
      for (i = 0; i < lim && done !== 1'b1 && !(fb_en === 1'b0 && f_csum === 1'b1); i = i + 1)
        @(posedge clk_sys);
      // Lets the closing state settle before anything is read
      repeat (10) @(posedge clk_sys);
    end
  endtask
  task test_done;
    begin
      if (fails == 0 && samples_checked > 0) begin
        $display("Result: passed");
      end else begin
        $display("Result: failed");
      end
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    boot(32'h11111111, U_DATA, 20000);
    chk(flags, 32'hc);
    chk(next_addr, ADDR_B);
    chk(nvalid, 3);
    chk(nclr, 2 * `MFL_CLEAR_CYCLES);
    chk(fb_act, 0);
    chk(last_data, U_DATA);
    // Junk ahead of the checksum span, clock rate clamped to the flash limit
    rate <= 8'h00;
    boot(32'hdeadbeef, U_DATA, 20000);
    chk(flags, 32'hc);
    rate <= 8'h04;
    boot(32'h11111111, U_DATA ^ 32'h00001100, 20000);
    chk(flags, 32'hf);
    chk(next_addr, ADDR_B);
    chk(nvalid, 4);
    chk(nclr, 3 * `MFL_CLEAR_CYCLES);
    chk(fb_act, 1);
    chk(last_data, G_DATA);
    fb_en <= 1'b0;
    boot(32'h11111111, U_DATA ^ 32'h00001100, 20000);
    chk({flags[30:0], init_b}, 32'hc);
    chk(fb_act, 0);
    fb_en <= 1'b1;
    mode_pins <= 3'h2;
    boot(32'h11111111, U_DATA, 600);
    chk({30'h0, ss_n, done}, 32'h2);
    test_done;
  end
endmodule

//--- hdl/mfl_loader.v
// Multiboot fallback loader: reads images from serial flash and falls back on an update-image checksum error
`timescale 1ns/1ns
`include "mfl_regs.vh"

// Operation
// R1 - Board straps mode pins to 001 to select serial flash loading.
// R2 - A pulse on the active-low restart pin starts a load from flash.
// R3 - Done goes high only after a load completes successfully.
// R4 - Checksum spans words from checksum reset up to the final check.
// R5 - Checksum mismatch in update image with fallback enabled reloads golden image.
// R6 - History records the reprogram attempt and a checksum error separately.
// R7 - History records that the fallback image loaded without error.
// R8 - Update image must sit at the next-image start address.
// R9 - Serial clock rate is limited to what the flash supports.
// R10 - Fallback pulls init and done low, clears memory, restarts at zero.
// R11 - Reprogram command jumps to the next-image start address.
// R12 - During fallback reload, next address and reprogram commands are ignored.
// R13 - Commands and address go out on MOSI, data returns on MISO.
// R14 - History flags and next address survive the fallback reset.
// R15 - Checksum is compared at the check command, before end of startup.
module mfl_loader (
  input  wire        clk_sys,
  input  wire        srst,
  input  wire        restart_n,
  input  wire [2:0]  mode_pins,
  input  wire        fallback_enable_option,
  input  wire [7:0]  config_clock_rate,
  input  wire        miso,
  output wire        sck,
  output wire        mosi,
  output reg         ss_n,
  output reg         init_b,
  output reg         done,
  output reg         cfg_clear,
  output reg         cfg_valid,
  output reg  [31:0] cfg_data,
  output reg         fallback_active,
  output reg         reprogram_attempt_flag,
  output reg         checksum_fail_flag,
  output reg         fallback_loaded_flag,
  output reg  [31:0] next_image_start_address
);

  localparam S_IDLE  = 3'h0;
  localparam S_CLEAR = 3'h1;
  localparam S_ADDR  = 3'h2;
  localparam S_READ  = 3'h3;
  localparam S_DONE  = 3'h4;
  localparam S_ERR   = 3'h5;

  // Wide constants, cut to the counter width on purpose
  localparam [31:0] HALF_MIN_W   = `MFL_MIN_HALF_DIV;
  localparam [31:0] CLEAR_LAST_W = `MFL_CLEAR_CYCLES - 1;

  reg [2:0]  state;
  reg [1:0]  rst_pin_sync;
  reg [1:0]  miso_pipe;
  reg [2:0]  mode_s1;
  reg [2:0]  mode_s2;
  reg        rst_pin_prev;
  reg [7:0]  clear_cnt;
  reg [31:0] load_addr;
  reg        synced;
  reg        await_addr;
  reg        await_csum;
  reg        csum_on;
  reg        csum_ok;
  reg [31:0] csum;
  reg        sh_start;
  reg [31:0] sh_tx;
  reg  [7:0] half_div;
  wire       sh_busy;
  wire       sh_done;
  wire [31:0] sh_rx;
  wire       miso_sync;
  wire       in_update;

  assign miso_sync = miso_pipe[1];
  assign in_update = reprogram_attempt_flag && !fallback_active;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; clock rate clamp keeps the flash inside its limit
  always @(posedge clk_sys) begin
    if (srst) begin
      rst_pin_sync <= 2'h3;
      miso_pipe    <= 2'h0;
      mode_s1      <= 3'h0;
      mode_s2      <= 3'h0;
      rst_pin_prev <= 1'b1;
      half_div     <= 8'h01;
    end else begin
      rst_pin_sync <= {rst_pin_sync[0], restart_n};
      miso_pipe    <= {miso_pipe[0], miso};
      mode_s1      <= mode_pins;
      mode_s2      <= mode_s1;
      rst_pin_prev <= rst_pin_sync[1];
      if (config_clock_rate < HALF_MIN_W[7:0])
        half_div <= HALF_MIN_W[7:0]; // [R9]
      else
        half_div <= config_clock_rate; // [R9]
    end
  end

  mfl_spi_shift u_shift (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .start     (sh_start),
    .tx_word   (sh_tx),
    .half_div  (half_div),
    .miso_sync (miso_sync),
    .busy      (sh_busy),
    .word_done (sh_done),
    .rx_word   (sh_rx),
    .sck       (sck),
    .mosi      (mosi)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Load sequencer
  always @(posedge clk_sys) begin
    if (srst) begin
      state                    <= S_IDLE;
      ss_n                     <= 1'b1;
      init_b                   <= 1'b0;
      done                     <= 1'b0;
      cfg_clear                <= 1'b0;
      cfg_valid                <= 1'b0;
      cfg_data                 <= 32'h00000000;
      fallback_active          <= 1'b0;
      reprogram_attempt_flag   <= 1'b0;
      checksum_fail_flag       <= 1'b0;
      fallback_loaded_flag     <= 1'b0;
      next_image_start_address <= 32'h00000000;
      clear_cnt                <= 8'h00;
      load_addr                <= `MFL_GOLDEN_ADDR;
      synced                   <= 1'b0;
      await_addr               <= 1'b0;
      await_csum               <= 1'b0;
      csum_on                  <= 1'b0;
      csum_ok                  <= 1'b0;
      csum                     <= 32'h00000000;
      sh_start                 <= 1'b0;
      sh_tx                    <= 32'h00000000;
    end else begin
      sh_start  <= 1'b0;
      cfg_clear <= 1'b0;
      cfg_valid <= 1'b0;
      if (!rst_pin_sync[1]) begin
        // Held in restart: the load is dropped back to idle with flash deselected, history is kept for reading
        state  <= S_IDLE;
        ss_n   <= 1'b1;
        init_b <= 1'b0;
        done   <= 1'b0;
      end else if (!rst_pin_prev) begin
        // Release of a restart pulse begins a fresh boot from address zero when the mode pins select serial flash
        if (mode_s2 == `MFL_MODE_SPI) begin // [R1]
          state                  <= S_CLEAR; // [R2]
          load_addr              <= `MFL_GOLDEN_ADDR;
          fallback_active        <= 1'b0;
          reprogram_attempt_flag <= 1'b0;
          checksum_fail_flag     <= 1'b0;
          fallback_loaded_flag   <= 1'b0;
          clear_cnt              <= 8'h00;
        end
      end else begin
        case (state)
          S_IDLE: begin
            init_b <= 1'b0;
          end
          S_CLEAR: begin
            ss_n      <= 1'b1;
            init_b    <= 1'b0; // [R10]
            done      <= 1'b0; // [R10]
            cfg_clear <= 1'b1; // [R10]
            synced    <= 1'b0;
            await_addr <= 1'b0;
            await_csum <= 1'b0;
            csum_on   <= 1'b0;
            csum_ok   <= 1'b0;
            csum      <= 32'h00000000;
            if (clear_cnt == CLEAR_LAST_W[7:0]) begin
              clear_cnt <= 8'h00;
              ss_n      <= 1'b0;
              sh_tx     <= {`MFL_FLASH_READ, load_addr[23:0]}; // [R13]
              sh_start  <= 1'b1;
              state     <= S_ADDR;
            end else begin
              clear_cnt <= clear_cnt + 8'h01;
            end
          end
          S_ADDR: begin
            // Init rises one cycle after the clear, never together with it
            init_b <= 1'b1; // [R10]
            if (sh_done) begin
              sh_tx    <= 32'h00000000;
              sh_start <= 1'b1;
              state    <= S_READ;
            end
          end
          S_READ: begin
            if (sh_done) begin
              sh_start <= 1'b1;
              if (!synced) begin
                if (sh_rx == `MFL_SYNC_WORD)
                  synced <= 1'b1;
              end else if (await_addr) begin
                await_addr <= 1'b0;
                if (csum_on)
                  csum <= csum + sh_rx; // [R4]
                if (!fallback_active)
                  next_image_start_address <= sh_rx; // [R12]
              end else if (await_csum) begin
                await_csum <= 1'b0;
                csum_on    <= 1'b0;
                if (csum == sh_rx) begin
                  csum_ok <= 1'b1; // [R15]
                end else begin
                  checksum_fail_flag <= 1'b1; // [R6]
                  sh_start           <= 1'b0;
                  if (in_update && fallback_enable_option) begin
                    fallback_active <= 1'b1; // [R5]
                    load_addr       <= `MFL_GOLDEN_ADDR; // [R10]
                    state           <= S_CLEAR; // [R14]
                  end else begin
                    state <= S_ERR;
                  end
                end
              end else if (sh_rx == `MFL_CMD_CSUM_RESET) begin
                csum    <= 32'h00000000; // [R4]
                csum_on <= 1'b1;
                csum_ok <= 1'b0;
              end else if (sh_rx == `MFL_CMD_NEXT_ADDR) begin
                await_addr <= 1'b1;
                if (csum_on)
                  csum <= csum + sh_rx; // [R4]
              end else if (sh_rx == `MFL_CMD_CSUM_CHECK) begin
                await_csum <= 1'b1;
                if (csum_on)
                  csum <= csum + sh_rx; // [R4]
              end else if (sh_rx == `MFL_CMD_REPROGRAM) begin
                if (fallback_active) begin // [R12]
                  // Swallowed on the fallback pass, so it never shows up as data
                  if (csum_on)
                    csum <= csum + sh_rx; // [R4]
                end else begin
                  reprogram_attempt_flag <= 1'b1; // [R6]
                  load_addr              <= next_image_start_address; // [R11]
                  sh_start               <= 1'b0;
                  state                  <= S_CLEAR;
                end
              end else if (sh_rx == `MFL_CMD_STARTUP_END) begin
                sh_start <= 1'b0;
                ss_n     <= 1'b1;
                // Startup without a passed check is treated as a failed load
                if (csum_ok) begin
                  state <= S_DONE;
                  done  <= 1'b1; // [R3]
                  if (fallback_active)
                    fallback_loaded_flag <= 1'b1; // [R7]
                end else begin
                  state <= S_ERR;
                end
              end else begin
                if (csum_on)
                  csum <= csum + sh_rx; // [R4]
                if (sh_rx != `MFL_CMD_NOOP) begin
                  cfg_valid <= 1'b1;
                  cfg_data  <= sh_rx;
                end
              end
            end
          end
          S_DONE: begin
            ss_n <= 1'b1;
          end
          S_ERR: begin
            ss_n   <= 1'b1;
            init_b <= 1'b0;
            done   <= 1'b0;
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule

//--- hdl/mfl_regs.vh
// Constants, command words and timing counts of the multiboot fallback loader
`ifndef MFL_REGS_VH
`define MFL_REGS_VH

`define MFL_CLK_MHZ         100
`define MFL_CLEAR_TIME_NS   1000
`define MFL_CLEAR_CYCLES    ((`MFL_CLEAR_TIME_NS * `MFL_CLK_MHZ + 999) / 1000)
`define MFL_FLASH_MAX_MHZ   20
`define MFL_MIN_HALF_DIV    ((`MFL_CLK_MHZ + 2 * `MFL_FLASH_MAX_MHZ - 1) / (2 * `MFL_FLASH_MAX_MHZ))

`define MFL_MODE_SPI        3'h1
`define MFL_FLASH_READ      8'h03
`define MFL_GOLDEN_ADDR     32'h00000000

`define MFL_SYNC_WORD       32'haa995566
`define MFL_CMD_NOOP        32'h20000000
`define MFL_CMD_CSUM_RESET  32'h30000001
`define MFL_CMD_NEXT_ADDR   32'h30000002
`define MFL_CMD_REPROGRAM   32'h30000003
`define MFL_CMD_CSUM_CHECK  32'h30000004
`define MFL_CMD_STARTUP_END 32'h30000005

`endif

//--- hdl/mfl_spi_shift.v
// Single-bit SPI mode 0 shifter moving one 32-bit word per start
`timescale 1ns/1ns
module mfl_spi_shift (
  input  wire        clk_sys,
  input  wire        srst,
  input  wire        start,
  input  wire [31:0] tx_word,
  input  wire [7:0]  half_div,
  input  wire        miso_sync,
  output reg         busy,
  output reg         word_done,
  output reg  [31:0] rx_word,
  output reg         sck,
  output reg         mosi
);

  reg [7:0]  div_cnt;
  reg [4:0]  bit_cnt;
  reg [31:0] shreg;

  ////////////////////////////////////////////////////////////////////////////
  // MOSI moves on the falling edge, MISO is taken on the rising edge
  always @(posedge clk_sys) begin
    if (srst) begin
      busy      <= 1'b0;
      word_done <= 1'b0;
      rx_word   <= 32'h00000000;
      sck       <= 1'b0;
      mosi      <= 1'b0;
      div_cnt   <= 8'h00;
      bit_cnt   <= 5'h00;
      shreg     <= 32'h00000000;
    end else begin
      word_done <= 1'b0;
      if (!busy) begin
        sck <= 1'b0;
        if (start) begin
          busy    <= 1'b1;
          shreg   <= tx_word;
          mosi    <= tx_word[31];
          div_cnt <= 8'h00;
          bit_cnt <= 5'h00;
        end
      end else if (div_cnt == half_div - 8'h01) begin
        div_cnt <= 8'h00;
        if (!sck) begin
          sck     <= 1'b1;
          rx_word <= {rx_word[30:0], miso_sync}; // [R13]
        end else begin
          sck <= 1'b0;
          if (bit_cnt == 5'h1f) begin
            busy      <= 1'b0;
            word_done <= 1'b1;
            mosi      <= 1'b0;
          end else begin
            bit_cnt <= bit_cnt + 5'h01;
            shreg   <= {shreg[30:0], 1'b0};
            mosi    <= shreg[30]; // [R13]
          end
        end
      end else begin
        div_cnt <= div_cnt + 8'h01;
      end
    end
  end

endmodule
